/* File: hdl/rcw_regs.vh */
// Constants of the runaway-code watchdog: address map, widths and timing counts.
`ifndef RCW_REGS_VH
`define RCW_REGS_VH

// Service location, shared with the low byte of the reset vector.
`define RCW_SERVICE_ADDR    16'hffff
// High byte of the reset vector; a read here marks a reset vector fetch.
`define RCW_VECTOR_HI_ADDR  16'hfffe

// Prescaler and counter widths.
`define RCW_PRE_W           12
`define RCW_CNT_W           6

// A service write clears prescaler stages 4 to 12, which are bits 3 and up.
`define RCW_SERVICE_CLR_LSB 3

// Prescaler bits below the counter for the short timeout.
`define RCW_SHORT_TAP       7

// Short timeout of 8176 and long timeout of 262128 oscillator cycles.
`define RCW_SHORT_TIMEOUT   13'h1ff0
`define RCW_LONG_TIMEOUT    18'h3fff0

// Reset pin low time of 32 oscillator cycles.
`define RCW_RST_PULSE       6'h20

// Prescaler clear 4096 oscillator cycles after power-up.
`define RCW_POR_DELAY       13'h1000

// System clock cycles per oscillator cycle.
`define RCW_OSC_DIV         4'h8

`endif

/* File: hdl/rcw_sync2.v */
// Two-flop synchroniser for levels that arrive from pins.
`timescale 1ns/1ps
`default_nettype none

module rcw_sync2 #(
    parameter WIDTH = 1
) (
    // Clock and reset.
    input  wire             clk_sys_i,
    input  wire             rst_i,
    // Asynchronous levels in, synchronised levels out.
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

`default_nettype wire

/* File: hdl/rcw_watchdog.v */
// Runaway-code watchdog: prescaler, timeout counter, service location and reset pulse.
// Notes on behaviour
// - 6-bit counter behind 12-bit oscillator prescaler.
// - Unserviced overflow resets after 8176 or 262128.
// - Length bit one short, zero long period.
// - Any write to service address restarts timeout.
// - Reading service address returns reset vector byte.
// - Reset drives pin low 32 cycles, sets cause.
// - Monitor mode plus test voltage disables watchdog.
// - Break plus test voltage on reset disables.
// - Stop clears prescaler and halts watchdog clock.
// - Prescaler cleared 4096 cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable input suppresses any watchdog reset.
// - Disable bit one off, zero running.
// - Watchdog keeps counting and resetting in wait.
// - Never raises an interrupt; reset only.
`timescale 1ns/1ps
`default_nettype none

`include "rcw_regs.vh"

module rcw_watchdog #(
    parameter [3:0]  OSC_DIV       = `RCW_OSC_DIV,
    parameter [12:0] SHORT_TIMEOUT = `RCW_SHORT_TIMEOUT,
    parameter [17:0] LONG_TIMEOUT  = `RCW_LONG_TIMEOUT,
    parameter [12:0] POR_DELAY     = `RCW_POR_DELAY
) (
    // Clock and power-on reset.
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // CPU bus.
    input  wire [15:0] addr_i,
    input  wire        wr_i,
    input  wire        rd_i,
    input  wire [7:0]  wdata_i,
    input  wire [7:0]  vector_lo_i,
    output wire [7:0]  rdata_o,
    // System integration.
    input  wire        internal_reset_i,
    input  wire        stop_exec_i,
    input  wire        stop_mode_i,
    input  wire        monitor_mode_i,
    input  wire        break_active_i,
    input  wire        cause_clear_i,
    // Write-once configuration bits.
    input  wire        watchdog_disable_i,
    input  wire        timeout_length_sel_i,
    // Test high voltage detectors on the reset and interrupt pins.
    input  wire        rst_pin_tst_i,
    input  wire        irq_pin_tst_i,
    // Open-drain reset pin, reset request and reset cause flag.
    output wire        rst_pin_o,
    output wire        rst_pin_oe_o,
    output wire        wd_reset_req_o,
    output wire        reset_cause_wd_o
);

    localparam [3:0]  OSC_LAST   = OSC_DIV - 4'h1;
    localparam [12:0] SHORT_LAST = SHORT_TIMEOUT - 13'h0001;
    localparam [17:0] LONG_LAST  = LONG_TIMEOUT - 18'h00001;

    // Pin levels are synchronised before use.
    wire [1:0] tst_sync;
    wire       rst_tst;
    wire       irq_tst;

    rcw_sync2 #(
        .WIDTH (2)
    ) u_tst_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .async_i   ({irq_pin_tst_i, rst_pin_tst_i}),
        .sync_o    (tst_sync)
    );

    assign rst_tst = tst_sync[0];
    assign irq_tst = tst_sync[1];

    // Oscillator-rate enable pulse derived from the system clock.
    reg [3:0] osc_div_ff;
    reg       osc_tick_ff;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            osc_div_ff  <= 4'h0;
            osc_tick_ff <= 1'b0;
        end
        else if (osc_div_ff == OSC_LAST)
        begin
            osc_div_ff  <= 4'h0;
            osc_tick_ff <= 1'b1;
        end
        else
        begin
            osc_div_ff  <= osc_div_ff + 4'h1;
            osc_tick_ff <= 1'b0;
        end
    end

    // Stop mode removes the oscillator from the prescaler and counter.
    wire wd_tick = osc_tick_ff & ~stop_mode_i;

    // Bus decode.
    wire service_wr = wr_i & (addr_i == `RCW_SERVICE_ADDR);
    wire service_rd = rd_i & (addr_i == `RCW_SERVICE_ADDR);
    wire vector_rd  = rd_i & (addr_i == `RCW_VECTOR_HI_ADDR);

    // The write data are ignored: only the access itself services the watchdog.
    wire unused_wdata = ^wdata_i;

    // Disable sources.
    wire wd_off = watchdog_disable_i
                | (monitor_mode_i & (rst_tst | irq_tst))
                | (break_active_i & rst_tst);

    // Power-on delay before the one-time prescaler clear.
    reg [12:0] por_cnt_ff;
    reg        por_done_ff;
    wire       por_clear = osc_tick_ff & ~por_done_ff & (por_cnt_ff == POR_DELAY - 13'h0001);

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            por_cnt_ff  <= 13'h0000;
            por_done_ff <= 1'b0;
        end
        else if (osc_tick_ff && !por_done_ff)
        begin
            por_cnt_ff <= por_cnt_ff + 13'h0001;
            if (por_clear)
            begin
                por_done_ff <= 1'b1;
            end
        end
    end

    // Prescaler, counter and overflow detection.
    reg [`RCW_PRE_W-1:0] pre_ff;
    reg [`RCW_CNT_W-1:0] cnt_ff;
    reg [`RCW_PRE_W-1:0] nxt_pre;
    reg [`RCW_CNT_W-1:0] nxt_cnt;
    reg                  fire;
    reg                  tap_roll;

    reg [5:0] pulse_cnt_ff;
    reg       pulse_ff;

    wire [12:0] short_elapsed = {cnt_ff, pre_ff[`RCW_SHORT_TAP-1:0]};
    wire [17:0] long_elapsed  = {cnt_ff, pre_ff};

    always @*
    begin
        nxt_pre  = pre_ff;
        nxt_cnt  = cnt_ff;
        fire     = 1'b0;
        tap_roll = 1'b0;
        if (wd_tick)
        begin
            nxt_pre = pre_ff + {{(`RCW_PRE_W-1){1'b0}}, 1'b1};
            if (timeout_length_sel_i)
            begin
                tap_roll = &pre_ff[`RCW_SHORT_TAP-1:0];
                fire     = (short_elapsed == SHORT_LAST);
            end
            else
            begin
                tap_roll = &pre_ff;
                fire     = (long_elapsed == LONG_LAST);
            end
            if (tap_roll)
            begin
                nxt_cnt = cnt_ff + {{(`RCW_CNT_W-1){1'b0}}, 1'b1};
            end
        end
        // Suppressed while disabled or while a pulse is already running.
        fire = fire & ~wd_off & ~pulse_ff;
        if (wd_off)
        begin
            // A re-enabled watchdog starts with a cleared counter; the prescaler keeps running while disabled.
            nxt_cnt = {`RCW_CNT_W{1'b0}};
        end
        if (stop_exec_i || vector_rd || por_clear)
        begin
            nxt_pre = {`RCW_PRE_W{1'b0}};
        end
        if (service_wr)
        begin
            nxt_pre[`RCW_PRE_W-1:`RCW_SERVICE_CLR_LSB] = {(`RCW_PRE_W-`RCW_SERVICE_CLR_LSB){1'b0}};
            nxt_cnt = {`RCW_CNT_W{1'b0}};
        end
        if (internal_reset_i || fire || pulse_ff)
        begin
            nxt_pre = {`RCW_PRE_W{1'b0}};
            nxt_cnt = {`RCW_CNT_W{1'b0}};
        end
    end

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pre_ff <= {`RCW_PRE_W{1'b0}};
            cnt_ff <= {`RCW_CNT_W{1'b0}};
        end
        else
        begin
            pre_ff <= nxt_pre;
            cnt_ff <= nxt_cnt;
        end
    end

    // Reset pulse on the open-drain pin, timed in oscillator cycles.
    reg rst_pin_ff;
    reg rst_pin_oe_ff;
    reg wd_req_ff;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pulse_ff      <= 1'b0;
            pulse_cnt_ff  <= 6'h00;
            rst_pin_ff    <= 1'b0;
            rst_pin_oe_ff <= 1'b0;
            wd_req_ff     <= 1'b0;
        end
        else if (fire)
        begin
            pulse_ff      <= 1'b1;
            pulse_cnt_ff  <= 6'h00;
            rst_pin_oe_ff <= 1'b1;
            wd_req_ff     <= 1'b1;
        end
        else if (pulse_ff && osc_tick_ff)
        begin
            if (pulse_cnt_ff == `RCW_RST_PULSE - 6'h01)
            begin
                pulse_ff      <= 1'b0;
                rst_pin_oe_ff <= 1'b0;
                wd_req_ff     <= 1'b0;
            end
            pulse_cnt_ff <= pulse_cnt_ff + 6'h01;
        end
    end

    // Cause flag survives the reset it causes; a new event wins over a clear.
    reg cause_ff;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cause_ff <= 1'b0;
        end
        else if (fire)
        begin
            cause_ff <= 1'b1;
        end
        else if (cause_clear_i)
        begin
            cause_ff <= 1'b0;
        end
    end

    // The service location reads back the reset vector, never watchdog state.
    reg [7:0] rdata_ff;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= 8'h00;
        end
        else if (service_rd)
        begin
            rdata_ff <= vector_lo_i;
        end
        else
        begin
            rdata_ff <= {7'h00, unused_wdata & 1'b0};
        end
    end

    assign rdata_o          = rdata_ff;
    assign rst_pin_o        = rst_pin_ff;
    assign rst_pin_oe_o     = rst_pin_oe_ff;
    assign wd_reset_req_o   = wd_req_ff;
    assign reset_cause_wd_o = cause_ff;

endmodule

`default_nettype wire

/* File: test/rcw_assertions.sv */
// Port checker for the runaway-code watchdog.
`timescale 1ns/1ps
`default_nettype none
module rcw_checker #(
    parameter [3:0] OSC_DIV = 4'h8
) (
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    input wire logic [15:0] addr_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [7:0]  vector_lo_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        stop_mode_i,
    input wire logic        monitor_mode_i,
    input wire logic        break_active_i,
    input wire logic        cause_clear_i,
    input wire logic        watchdog_disable_i,
    input wire logic        rst_pin_tst_i,
    input wire logic        irq_pin_tst_i,
    input wire logic        rst_pin_o,
    input wire logic        rst_pin_oe_o,
    input wire logic        wd_reset_req_o,
    input wire logic        reset_cause_wd_o
);
    logic [15:0] hi_ff;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // Length of the current low pulse in system cycles.
    always @(posedge clk_sys_i or posedge rst_i)
        if (rst_i)
            hi_ff <= 16'h0000;
        else
            hi_ff <= rst_pin_oe_o ? hi_ff + 16'h0001 : 16'h0000;
    AST_PIN_LOW: assert property (rst_pin_oe_o |-> !rst_pin_o)
        else $error("reset pin driven high");
    AST_REQ_OE: assert property (wd_reset_req_o == rst_pin_oe_o)
        else $error("request and pin drive differ");
    AST_PULSE_LEN: assert property ($fell(rst_pin_oe_o) |-> hi_ff == {7'h00, OSC_DIV, 5'h00})
        else $error("reset pulse length wrong");
    AST_CAUSE_SET: assert property ($rose(wd_reset_req_o) |-> reset_cause_wd_o)
        else $error("cause flag not set");
    AST_CAUSE_HOLD: assert property (reset_cause_wd_o && !cause_clear_i |=> reset_cause_wd_o)
        else $error("cause flag lost");
    AST_DIS: assert property ($rose(wd_reset_req_o) |-> !$past(watchdog_disable_i))
        else $error("reset while disabled");
    AST_READ: assert property (rd_i && addr_i == 16'hffff |=> rdata_o == $past(vector_lo_i))
        else $error("service read not vector byte");
    AST_SVC: assert property ((wr_i && addr_i == 16'hffff) ##1 !wd_reset_req_o
        |=> !wd_reset_req_o [*8]) else $error("reset soon after service");
    AST_MON: assert property ((monitor_mode_i && (rst_pin_tst_i || irq_pin_tst_i)) [*5]
        |-> !$rose(wd_reset_req_o)) else $error("reset in monitor mode");
    AST_BRK: assert property ((break_active_i && rst_pin_tst_i) [*5]
        |-> !$rose(wd_reset_req_o)) else $error("reset in break");
    AST_STOP: assert property (stop_mode_i [*2] |-> !$rose(wd_reset_req_o))
        else $error("reset in stop mode");
    cover property ($rose(wd_reset_req_o));
    cover property ($fell(rst_pin_oe_o));
    cover property (rd_i && addr_i == 16'hffff);
endmodule
bind rcw_watchdog rcw_checker #(.OSC_DIV(OSC_DIV)) u_chk (
    .clk_sys_i          (clk_sys_i),
    .rst_i              (rst_i),
    .addr_i             (addr_i),
    .wr_i               (wr_i),
    .rd_i               (rd_i),
    .vector_lo_i        (vector_lo_i),
    .rdata_o            (rdata_o),
    .stop_mode_i        (stop_mode_i),
    .monitor_mode_i     (monitor_mode_i),
    .break_active_i     (break_active_i),
    .cause_clear_i      (cause_clear_i),
    .watchdog_disable_i (watchdog_disable_i),
    .rst_pin_tst_i      (rst_pin_tst_i),
    .irq_pin_tst_i      (irq_pin_tst_i),
    .rst_pin_o          (rst_pin_o),
    .rst_pin_oe_o       (rst_pin_oe_o),
    .wd_reset_req_o     (wd_reset_req_o),
    .reset_cause_wd_o   (reset_cause_wd_o)
);
`default_nettype wire

/* File: test/rcw_cpu_model.sv */
// CPU bus master model holding the reset vector byte.
`timescale 1ns/1ps
`default_nettype none
module rcw_cpu_model #(
    parameter [7:0] VEC = 8'h5a
) (
    input  wire logic        clk_i,
    output var  logic [15:0] addr_o,
    output var  logic        wr_o,
    output var  logic        rd_o,
    output var  logic [7:0]  wdata_o,
    output wire logic [7:0]  vec_o
);
    assign vec_o = VEC;
    initial
    begin
        addr_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end
    // One strobe per access; the address is inverted on release so no stale value lingers.
    task automatic acc(input logic w, input logic [15:0] a);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wr_o = w;
        rd_o = !w;
        wdata_o = wdata_o + 8'h3b;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask
endmodule
`default_nettype wire

/* File: test/rcw_watchdog_test.sv */
// Self-checking bench for the runaway-code watchdog.
`timescale 1ns/1ps
`default_nettype none
module rcw_watchdog_test;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [9:0]  cfg = 10'h000;
    wire  [15:0] addr;
    wire  [7:0]  wdata, vec, rdata;
    wire         wr, rd, pin, oe, req, cause;
    int          num_errors = 0;
    int          n_checks = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    rcw_cpu_model u_cpu (.clk_i(clk_sys_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata), .vec_o(vec));
    rcw_watchdog #(.OSC_DIV(4'h1), .SHORT_TIMEOUT(13'h0040), .LONG_TIMEOUT(18'h00100),
        .POR_DELAY(13'h0010)) u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .wdata_i(wdata), .vector_lo_i(vec), .rdata_o(rdata),
        .internal_reset_i(cfg[0]), .stop_exec_i(cfg[1]), .stop_mode_i(cfg[2]),
        .monitor_mode_i(cfg[3]), .break_active_i(cfg[4]), .cause_clear_i(cfg[5]),
        .watchdog_disable_i(cfg[6]), .timeout_length_sel_i(cfg[7]),
        .rst_pin_tst_i(cfg[8]), .irq_pin_tst_i(cfg[9]), .rst_pin_o(pin),
        .rst_pin_oe_o(oe), .wd_reset_req_o(req), .reset_cause_wd_o(cause));
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", s, e, g);
            num_errors++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic quiet(input int n);
        logic hit;
        hit = 1'b0;
        repeat (n)
        begin
            @(posedge clk_sys_i);
            #1;
            hit = hit | (req !== 1'b0);
        end
        chk("req", 16'h0, {15'h0, hit});
    endtask
    task automatic t_read;
        u_cpu.acc(1'b0, 16'hffff);
        chk("rdata", 16'h5a, {8'h0, rdata});
        cyc(1);
        chk("rdata", 16'h0, {8'h0, rdata});
        u_cpu.acc(1'b0, 16'h1234);
        chk("rdata", 16'h0, {8'h0, rdata});
    endtask
    // A vector fetch then a service start the period from a cleared count.
    task automatic t_fire(input logic sel, input int n);
        int c;
        cfg[5] = 1'b1;
        cfg[1] = 1'b0;
        cfg[7] = sel;
        cyc(1);
        cfg[5] = 1'b0;
        chk("cause", 16'h0, {15'h0, cause});
        u_cpu.acc(1'b0, 16'hfffe);
        u_cpu.acc(1'b1, 16'hffff);
        c = 0;
        while (req !== 1'b1 && c < 600)
        begin
            cyc(1);
            c++;
        end
        chk("timeout", 16'h1, 16'(c >= n - 10 && c <= n + 2));
        chk("cause", 16'h1, {15'h0, cause});
        chk("pin", 16'h0, {15'h0, pin});
        c = 0;
        while (oe === 1'b1 && c < 100)
        begin
            cyc(1);
            c++;
        end
        chk("pulse", 16'd32, 16'(c));
    endtask
    task automatic t_service;
        cfg[7] = 1'b1;
        repeat (6)
        begin
            u_cpu.acc(1'b1, 16'hffff);
            quiet(40);
        end
        cfg[0] = 1'b1;
        cyc(2);
        cfg[0] = 1'b0;
        quiet(40);
        cfg[5] = 1'b1;
        cyc(1);
        cfg[5] = 1'b0;
        cyc(1);
        chk("cause", 16'h0, {15'h0, cause});
    endtask
    task automatic t_hold;
        logic [9:0] m[5] = '{10'h040, 10'h208, 10'h108, 10'h110, 10'h006};
        foreach (m[i])
        begin
            u_cpu.acc(1'b1, 16'hffff);
            cfg = cfg | m[i];
            cyc(1);
            cfg[1] = 1'b0;
            quiet(150);
            // Service while still held off: the free prescaler could otherwise fire at release.
            u_cpu.acc(1'b1, 16'hffff);
            cfg = cfg & ~m[i];
        end
    endtask
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        rst_i = 1'b0;
        cyc(20);
        t_read;
        t_fire(1'b1, 64);
        t_fire(1'b0, 256);
        t_service;
        t_hold;
        end_sim;
    end
    initial
    begin
        #150000;
        num_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
